// >>> verilog/fault_protect.v
/*
 * Digital fault protection and reporting for a synchronous buck stage:
 * UV retry and blanking, fixed/relative OV, OT, boot UVLO, high-side
 * short, minimum off-time and target address forming.
 * Assumes voltages arrive as mV codes synchronous to clk, comparators
 * as synchronous levels, and a register port from the serial target.
 */
// Operation
// - Retry timer end: start if low and retry forever, else rewait
// - UV blanking select suppresses UV per code
// - OV blanking select suppresses OV per code
// - Fixed OV at boot, transitions, disabled; else relative
// - 3-bit field selects eight fixed OV thresholds
// - OV responses: ignore, shutdown, retry N, forever; fixed OV never retries
// - Relative OV threshold 50-400 mV in 50 mV
// - Override bit makes register threshold win
// - Fixed OV: flag, low-side on until threshold
// - Relative OV: flag, ramp target down, low-side on
// - OT responses ignore/shutdown/retry; held until reset unless retry forever
// - OT fault tri-states; retry below warning limit
// - Tenth boot UV cycle faults; three clean reset
// - Boot UV fault latches, sticky failure code
// - Check switch node while low-side is active
// - High-side short: outputs, low-side on, stop
// - High-side short sticky until power cycle
// - Configurable 7-bit address, lockable once set
// - Strap offset added to base address
// - Offset disable bit: 0 enables, 1 disables
// - Hold synchronous switch for minimum off-time
// - Report OC, OV, UV, OT, boot UVLO, supply UVLO
// - UV retry timer 1-8 ms, output tri-stated
// - Retry check against fixed 250 mV level
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_defines.vh"

module fault_protect #(
    parameter integer UV_STEP_CYCLES = `UV_RETRY_STEP_CYC,
    parameter integer MIN_OFF_CYCLES = 20
) (
    // Clock and synchronous reset (reset mirrors supply/enable cycling)
    input  wire        clk,
    input  wire        nrst,
    // Register port
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    // Operating context
    input  wire        enable_in,
    input  wire        boot_phase,
    input  wire        dynamic_voltage_transition,
    input  wire        transition_up,
    // Measurements and programmed values in mV
    input  wire [11:0] vout_mv,
    input  wire [11:0] voltage_target,
    input  wire [11:0] pmbus_rel_ov_mv,
    input  wire [11:0] uv_limit_mv,
    // Comparator levels and responses from the command layer
    input  wire        ot_fault_in,
    input  wire        ot_warn_in,
    input  wire        oc_fault_in,
    input  wire        vcc_uvlo_in,
    input  wire [1:0]  ov_response,
    input  wire [2:0]  ov_retry_limit,
    input  wire [1:0]  uv_response,
    input  wire [1:0]  ot_response,
    input  wire        pwm_cycle_end,
    input  wire        boot_uv_seen,
    input  wire        switch_node_high,
    input  wire        pwm_request,
    // Address forming
    input  wire [6:0]  base_addr,
    input  wire [6:0]  address_strap_pin,
    output reg  [6:0]  target_addr,
    // Power stage and status
    output reg         hs_on,
    output reg         ls_on,
    output reg         startup_req,
    output reg  [11:0] ramped_target,
    output reg         regulator_ready_out,
    output reg         catastrophic_fault_out_n,
    output reg         current_report_en,
    output reg  [5:0]  fault_report
);

    reg [15:0] aoc_ff, rtc_ff, pc_ff;
    reg [6:0]  addr_base_ff;
    reg        addr_locked_ff;
    reg        fov_act_ff, rov_act_ff, ov_latched_ff;
    reg [2:0]  ov_count_ff;
    reg        ot_act_ff, uv_wait_ff;
    reg [22:0] uv_timer_ff;
    reg [3:0]  boot_cnt_ff;
    reg [1:0]  clean_cnt_ff;
    reg        boot_fault_ff, hss_ff;
    reg [15:0] off_cnt_ff;
    reg [5:0]  sticky_code_ff;

    function blanked;
        input [1:0] sel;
        input       boot, dvt, up;
        begin
            case (sel)
                `BLANK_UP_DOWN: blanked = boot | dvt;
                `BLANK_UP:      blanked = boot | (dvt & up);
                `BLANK_BOOT:    blanked = boot;
                default:        blanked = 1'b0;
            endcase
        end
    endfunction

    function [11:0] fov_level;
        input [2:0] code;
        begin
            case (code)
                3'h0:    fov_level = `FOV_MV_0;
                3'h1:    fov_level = `FOV_MV_1;
                3'h2:    fov_level = `FOV_MV_2;
                3'h3:    fov_level = `FOV_MV_3;
                3'h4:    fov_level = `FOV_MV_4;
                3'h5:    fov_level = `FOV_MV_5;
                3'h6:    fov_level = `FOV_MV_6;
                default: fov_level = `FOV_MV_7;
            endcase
        end
    endfunction

    wire uv_blank = blanked(pc_ff[`PC_UV_BLANK_LSB+1:`PC_UV_BLANK_LSB], boot_phase,
                            dynamic_voltage_transition, transition_up);
    wire ov_blank = blanked(pc_ff[`PC_OV_BLANK_LSB+1:`PC_OV_BLANK_LSB], boot_phase,
                            dynamic_voltage_transition, transition_up);
    wire fixed_mode = boot_phase | dynamic_voltage_transition | ~enable_in;
    wire [11:0] fov_thr = fov_level(pc_ff[`PC_FIXED_OV_LSB+2:`PC_FIXED_OV_LSB]);
    wire [11:0] rel_reg_mv = ({9'h000, rtc_ff[`RTC_REL_OV_LSB+2:`RTC_REL_OV_LSB]}
                              + 12'h001) * `REL_OV_STEP_MV;
    wire [11:0] rel_mv = rtc_ff[`RTC_REL_OV_OVERRIDE] ? rel_reg_mv
                                                      : pmbus_rel_ov_mv;
    wire [12:0] rov_thr = {1'b0, voltage_target} + {1'b0, rel_mv};
    wire ov_ok = (ov_response != `RESP_IGNORE) & ~ov_blank & ~ov_latched_ff;
    wire fov_evt = ov_ok & fixed_mode & (vout_mv > fov_thr);
    wire rov_evt = ov_ok & ~fixed_mode & ({1'b0, vout_mv} > rov_thr);
    wire uv_evt = (uv_response != `RESP_IGNORE) & ~uv_blank & ~uv_wait_ff
                  & ~boot_phase & (vout_mv < uv_limit_mv);
    wire [22:0] uv_len = (23'h000001 + {20'h00000, pc_ff[`PC_UV_RETRY_LSB+2:`PC_UV_RETRY_LSB]})
                         * UV_STEP_CYCLES[22:0];
    wire stop_all = hss_ff | boot_fault_ff | ot_act_ff | uv_wait_ff | ov_latched_ff;

    // Registers; the lock bit freezes the address base once set
    always @(posedge clk) begin
        if (!nrst) begin
            aoc_ff         <= `AOC_RESET;
            rtc_ff         <= `RTC_RESET;
            pc_ff          <= `PC_RESET;
            addr_base_ff   <= 7'h00;
            addr_locked_ff <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_OFFSET_CONTROL: begin
                    if (!addr_locked_ff) begin
                        aoc_ff         <= reg_wdata;
                        addr_base_ff   <= base_addr;
                        addr_locked_ff <= reg_wdata[`AOC_LOCK];
                    end
                end
                `RELATIVE_THRESH_CFG: rtc_ff <= reg_wdata;
                `PROTECTION_CONFIG:   pc_ff  <= reg_wdata;
                default: ;
            endcase
        end
    end

    always @* begin
        case (reg_addr)
            `ADDR_OFFSET_CONTROL: reg_rdata = aoc_ff;
            `RELATIVE_THRESH_CFG: reg_rdata = rtc_ff;
            `PROTECTION_CONFIG:   reg_rdata = pc_ff;
            `FAULT_STATUS_REG:    reg_rdata = {10'h000, sticky_code_ff};
            default:              reg_rdata = 16'h0000;
        endcase
    end

    // Protection state
    always @(posedge clk) begin
        if (!nrst) begin
            fov_act_ff <= 1'b0;
            rov_act_ff <= 1'b0;
            ov_latched_ff <= 1'b0;
            ov_count_ff <= 3'h0;
            ot_act_ff <= 1'b0;
            uv_wait_ff <= 1'b0;
            uv_timer_ff <= 23'h000000;
            boot_cnt_ff <= 4'h0;
            clean_cnt_ff <= 2'h0;
            boot_fault_ff <= 1'b0;
            hss_ff <= 1'b0;
            off_cnt_ff <= 16'h0000;
            sticky_code_ff <= 6'h00;
            ramped_target <= 12'h000;
            startup_req <= 1'b0;
        end else begin
            startup_req <= 1'b0;
            if (fov_evt) begin
                fov_act_ff <= 1'b1;
            end else if (fov_act_ff && vout_mv <= fov_thr) begin
                fov_act_ff <= 1'b0;
                ov_latched_ff <= 1'b1;
            end
            if (rov_evt && !rov_act_ff) begin
                rov_act_ff <= 1'b1;
                ramped_target <= voltage_target;
            end else if (rov_act_ff) begin
                // Ramp is one step per clock; the analog slew owns the real rate
                ramped_target <= (ramped_target > `REL_OV_STEP_MV) ?
                                 ramped_target - `REL_OV_STEP_MV : 12'h000;
                if (vout_mv <= ramped_target || ramped_target == 12'h000) begin
                    rov_act_ff <= 1'b0;
                    case (ov_response)
                        `RESP_SHUTDOWN: ov_latched_ff <= 1'b1;
                        `RESP_RETRY_N: begin
                            if (ov_count_ff >= ov_retry_limit ||
                                ov_count_ff >= `OV_RETRY_MAX)
                                ov_latched_ff <= 1'b1;
                            else
                                ov_count_ff <= ov_count_ff + 3'h1;
                        end
                        default: ;
                    endcase
                end
            end else begin
                ramped_target <= voltage_target;
            end
            // Temperature fault holds until reset unless the response is retry forever
            if (ot_response != `RESP_IGNORE && ot_fault_in)
                ot_act_ff <= 1'b1;
            else if (ot_act_ff && ot_response == `RESP_RETRY_FOREVER && !ot_warn_in)
                ot_act_ff <= 1'b0;
            if (uv_evt) begin
                uv_wait_ff <= 1'b1;
                uv_timer_ff <= uv_len;
            end else if (uv_wait_ff) begin
                if (uv_timer_ff > 23'h000001) begin
                    uv_timer_ff <= uv_timer_ff - 23'h000001;
                end else if (uv_response == `RESP_RETRY_FOREVER &&
                             vout_mv < `UV_CHECK_MV) begin
                    uv_wait_ff <= 1'b0;
                    startup_req <= 1'b1;
                end else begin
                    uv_timer_ff <= uv_len;
                end
            end
            if (pwm_cycle_end) begin
                if (boot_uv_seen) begin
                    clean_cnt_ff <= 2'h0;
                    if (boot_cnt_ff + 4'h1 >= `BOOT_UV_FAULT_COUNT)
                        boot_fault_ff <= 1'b1;
                    else
                        boot_cnt_ff <= boot_cnt_ff + 4'h1;
                end else if (clean_cnt_ff + 2'h1 >= `BOOT_UV_CLEAN_COUNT) begin
                    clean_cnt_ff <= 2'h0;
                    boot_cnt_ff <= 4'h0;
                end else begin
                    clean_cnt_ff <= clean_cnt_ff + 2'h1;
                end
            end
            if (ls_on && switch_node_high)
                hss_ff <= 1'b1;
            off_cnt_ff <= ls_on ? ((off_cnt_ff == 16'hFFFF) ? off_cnt_ff
                                   : off_cnt_ff + 16'h0001) : 16'h0000;
            sticky_code_ff <= sticky_code_ff | {vcc_uvlo_in, boot_fault_ff,
                              ot_act_ff, uv_wait_ff, fov_evt | rov_evt,
                              oc_fault_in};
        end
    end

    // Gate drive and status outputs
    always @(posedge clk) begin
        if (!nrst) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            regulator_ready_out <= 1'b0;
            catastrophic_fault_out_n <= 1'b1;
            current_report_en <= 1'b0;
            fault_report <= 6'h00;
            target_addr <= 7'h00;
        end else begin
            if (hss_ff) begin
                hs_on <= 1'b0;
                ls_on <= 1'b1;
            end else if (fov_act_ff || rov_act_ff) begin
                hs_on <= 1'b0;
                ls_on <= 1'b1;
            end else if (stop_all || !enable_in) begin
                hs_on <= 1'b0;
                ls_on <= 1'b0;
            end else if (pwm_request &&
                         off_cnt_ff >= MIN_OFF_CYCLES[15:0]) begin
                hs_on <= 1'b1;
                ls_on <= 1'b0;
            end else begin
                hs_on <= 1'b0;
                ls_on <= 1'b1;
            end
            regulator_ready_out <= enable_in & ~stop_all & ~fov_act_ff & ~rov_act_ff;
            catastrophic_fault_out_n <= ~(hss_ff | boot_fault_ff | ov_latched_ff);
            current_report_en <= ~hss_ff;
            fault_report <= sticky_code_ff;
            target_addr <= aoc_ff[`AOC_OFFSET_DISABLE] ? addr_base_ff
                           : addr_base_ff + address_strap_pin;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/fault_protect_defines.vh
/*
 * Offsets, field positions, reset values and timing counts for the
 * regulator fault-protection block.
 * Assumes a 100 MHz core clock; included by bare name.
 */
`ifndef FAULT_PROTECT_DEFINES_VH
`define FAULT_PROTECT_DEFINES_VH

// Register offsets (16-bit registers, byte-style register address)
`define ADDR_OFFSET_CONTROL   8'h42
`define RELATIVE_THRESH_CFG   8'h5E
`define PROTECTION_CONFIG     8'h60
`define FAULT_STATUS_REG      8'h62

// Field positions
`define AOC_OFFSET_DISABLE    6
`define RTC_REL_OV_LSB        12
`define RTC_REL_OV_OVERRIDE   15
`define PC_FIXED_OV_LSB       0
`define PC_UV_RETRY_LSB       4
`define PC_UV_BLANK_LSB       10
`define PC_OV_BLANK_LSB       12
`define AOC_LOCK              7

// Reset values
`define AOC_RESET             16'h0000
`define RTC_RESET             16'h0000
`define PC_RESET              16'h0000

// Blanking select codes
`define BLANK_NONE            2'h0
`define BLANK_BOOT            2'h1
`define BLANK_UP              2'h2
`define BLANK_UP_DOWN         2'h3

// Fault responses
`define RESP_IGNORE           2'h0
`define RESP_SHUTDOWN         2'h1
`define RESP_RETRY_N          2'h2
`define RESP_RETRY_FOREVER    2'h3

// Timing
`define CLK_PERIOD_NS         10
`define UV_RETRY_STEP_US      1000
`define UV_RETRY_STEP_CYC     ((`UV_RETRY_STEP_US * 1000) / `CLK_PERIOD_NS)
`define BOOT_UV_FAULT_COUNT   4'hA
`define BOOT_UV_CLEAN_COUNT   2'h3
`define OV_RETRY_MAX          3'h6

// Fixed over-voltage levels in mV, ascending with the code; then UV check level and relative OV step in mV
`define FOV_MV_0              12'h320
`define FOV_MV_1              12'h3E8
`define FOV_MV_2              12'h4B0
`define FOV_MV_3              12'h546
`define FOV_MV_4              12'h5DC
`define FOV_MV_5              12'h708
`define FOV_MV_6              12'h898
`define FOV_MV_7              12'hB22
`define UV_CHECK_MV           12'h0FA
`define REL_OV_STEP_MV        12'h032

`endif

// >>> dv/fault_protect_props.sv
/* Assertion checker for fault_protect: high-side short, off-time,
   over-temperature and boot UV counting, sticky fault reporting.
   Assumes it is bound to the top and nrst is held at least two edges. */
`timescale 1ns/1ps
`default_nettype none
module fault_protect_props #(
    parameter integer UV_STEP_CYCLES = 10,
    parameter integer MIN_OFF_CYCLES = 20
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Power stage and status
    input wire logic       hs_on,
    input wire logic       ls_on,
    input wire logic       regulator_ready_out,
    input wire logic       catastrophic_fault_out_n,
    input wire logic       current_report_en,
    input wire logic [5:0] fault_report,
    // Stimulus seen by the block
    input wire logic       switch_node_high,
    input wire logic       ot_fault_in,
    input wire logic [1:0] ot_response,
    input wire logic       pwm_cycle_end,
    input wire logic       boot_uv_seen
);
    logic [7:0] ls_cnt_ff;
    logic       hs_seen_ff;
    logic [3:0] viol_cnt_ff;
    logic [1:0] clean_cnt_ff;
    // Off-time counter saturates so long idle spells never wrap
    always @(posedge clk) begin
        if (!nrst || hs_on) begin
            ls_cnt_ff <= 8'h00;
        end else if (ls_on && ls_cnt_ff != 8'hFF) begin
            ls_cnt_ff <= ls_cnt_ff + 8'h01;
        end
        hs_seen_ff <= nrst && (hs_seen_ff || hs_on);
    end
    always @(posedge clk) begin
        if (!nrst || (pwm_cycle_end && !boot_uv_seen && clean_cnt_ff == 2'h2)) begin
            viol_cnt_ff <= 4'h0;
            clean_cnt_ff <= 2'h0;
        end else if (pwm_cycle_end && boot_uv_seen) begin
            viol_cnt_ff <= (viol_cnt_ff == 4'hA) ? 4'hA : viol_cnt_ff + 4'h1;
            clean_cnt_ff <= 2'h0;
        end else if (pwm_cycle_end) begin
            clean_cnt_ff <= clean_cnt_ff + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_hss_trip;
        ls_on && switch_node_high;
    endsequence
    sequence s_hss_state;
        ls_on && !hs_on && !catastrophic_fault_out_n && !regulator_ready_out;
    endsequence
    property p_hss_detect;
        s_hss_trip |-> ##[1:3] !catastrophic_fault_out_n;
    endproperty
    property p_hss_state;
        $fell(current_report_en) |-> s_hss_state ##1 s_hss_state;
    endproperty
    property p_hss_sticky;
        $fell(current_report_en) |=> (!current_report_en && !catastrophic_fault_out_n) [*8];
    endproperty
    property p_min_off;
        $rose(hs_on) && hs_seen_ff |-> ls_cnt_ff >= MIN_OFF_CYCLES;
    endproperty
    property p_ot_tristate;
        // A high-side short keeps the low side on, so it is left out here
        (ot_fault_in && current_report_en &&
         (ot_response == 2'h1 || ot_response == 2'h3)) [*3] |-> !hs_on && !ls_on;
    endproperty
    property p_boot_uv_rise;
        $rose(fault_report[4]) |-> viol_cnt_ff == 4'hA;
    endproperty
    property p_boot_uv_set;
        viol_cnt_ff == 4'hA |-> ##[0:4] fault_report[4];
    endproperty
    property p_sticky;
        1'b1 |=> (fault_report & $past(fault_report)) == $past(fault_report);
    endproperty
    a_hss_detect: assert property (p_hss_detect) else $error("short not flagged");
    a_hss_state: assert property (p_hss_state) else $error("short outputs wrong");
    a_hss_sticky: assert property (p_hss_sticky) else $error("short fault cleared");
    a_min_off: assert property (p_min_off) else $error("off-time too short");
    a_ot_tristate: assert property (p_ot_tristate) else $error("switches driven in OT");
    a_boot_uv_rise: assert property (p_boot_uv_rise) else $error("boot UV early");
    a_boot_uv_set: assert property (p_boot_uv_set) else $error("boot UV missing");
    a_sticky: assert property (p_sticky) else $error("fault report bit cleared");
endmodule
bind fault_protect fault_protect_props #(.UV_STEP_CYCLES(UV_STEP_CYCLES),
    .MIN_OFF_CYCLES(MIN_OFF_CYCLES)) i_props (.clk, .nrst, .hs_on, .ls_on,
    .regulator_ready_out, .catastrophic_fault_out_n, .current_report_en, .fault_report,
    .switch_node_high, .ot_fault_in, .ot_response, .pwm_cycle_end, .boot_uv_seen);
`default_nettype wire

// >>> dv/host_model.sv
/* Management host model: issues register writes and reads on the
   strobe port. Assumes the read data is combinational from the address. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic             reg_wr,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Stale data is inverted so a late capture cannot pass by luck
        reg_wdata <= ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
/* Self-checking bench for fault_protect with the host model on the
   register port. Assumes short UV step and default off-time counts. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, nrst, enable_in, boot_phase, dynamic_voltage_transition, transition_up;
    logic        ot_fault_in, ot_warn_in, oc_fault_in, vcc_uvlo_in, pwm_cycle_end, boot_uv_seen;
    logic        switch_node_high, pwm_request, reg_wr, hs_on, ls_on, startup_req;
    logic        regulator_ready_out, catastrophic_fault_out_n, current_report_en, s;
    logic [11:0] vout_mv, voltage_target, pmbus_rel_ov_mv, uv_limit_mv, ramped_target;
    logic [1:0]  ov_response, uv_response, ot_response;
    logic [2:0]  ov_retry_limit;
    logic [6:0]  base_addr, address_strap_pin, target_addr;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [5:0]  fault_report;
    int          n_mismatch = 0, cmp_count = 0, n;
    fault_protect #(.UV_STEP_CYCLES(10), .MIN_OFF_CYCLES(20)) i_dut (.clk, .nrst, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .enable_in, .boot_phase, .dynamic_voltage_transition,
        .transition_up, .vout_mv, .voltage_target, .pmbus_rel_ov_mv, .uv_limit_mv, .ot_fault_in,
        .ot_warn_in, .oc_fault_in, .vcc_uvlo_in, .ov_response, .ov_retry_limit, .uv_response,
        .ot_response, .pwm_cycle_end, .boot_uv_seen, .switch_node_high, .pwm_request, .base_addr,
        .address_strap_pin, .target_addr, .hs_on, .ls_on, .startup_req, .ramped_target,
        .regulator_ready_out, .catastrophic_fault_out_n, .current_report_en, .fault_report);
    host_model i_host (.clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rst();
        {nrst, enable_in, boot_phase, dynamic_voltage_transition, transition_up} <= 5'h00;
        {ot_fault_in, ot_warn_in, oc_fault_in, vcc_uvlo_in, pwm_cycle_end} <= 5'h00;
        {boot_uv_seen, switch_node_high, pwm_request} <= 3'h0;
        {vout_mv, voltage_target, pmbus_rel_ov_mv, uv_limit_mv} <= {12'h000, 12'h3E8, 24'h0};
        {ov_response, uv_response, ot_response, ov_retry_limit} <= 9'h000;
        {base_addr, address_strap_pin} <= 14'h0000;
        repeat (2) @(posedge clk);
        {nrst, enable_in} <= 2'h3;
    endtask
    task automatic pulses(input int k, input logic v);
        repeat (k) begin
            @(posedge clk);
            {pwm_cycle_end, boot_uv_seen} <= {1'b1, v};
            @(posedge clk);
            pwm_cycle_end <= 1'b0;
        end
    endtask
    // Samples after the edge settles; counts cycles hs_on stays away from v
    task automatic wait_hs(input logic v);
        for (n = 0; n < 100 && hs_on !== v; n++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
    endtask
    task automatic see_start(input int k);
        s = 1'b0;
        repeat (k) begin
            @(posedge clk);
            #1;
            s = s | startup_req;
        end
    endtask
    task automatic t_regs();
        i_host.read_reg(8'h60, d);
        check("prot reset", d, 16'h0000);
        i_host.write_reg(8'h60, 16'h3C07);
        i_host.write_reg(8'h5E, 16'hF000);
        i_host.write_reg(8'h10, 16'hFFFF);
        i_host.read_reg(8'h60, d);
        check("blank and level", d & 16'h3C07, 16'h3C07);
        i_host.read_reg(8'h5E, d);
        check("relative level", d & 16'hF000, 16'hF000);
        i_host.read_reg(8'h10, d);
        check("unmapped", d, 16'h0000);
    endtask
    task automatic t_addr();
        {base_addr, address_strap_pin} <= {7'h28, 7'h0F};
        i_host.write_reg(8'h42, 16'h0000);
        repeat (3) @(posedge clk);
        check("offset addr", 16'(target_addr), 16'h0037);
        i_host.write_reg(8'h42, 16'h0040);
        repeat (3) @(posedge clk);
        check("plain addr", 16'(target_addr), 16'h0028);
        i_host.write_reg(8'h42, 16'h0080);
        base_addr <= 7'h11;
        i_host.write_reg(8'h42, 16'h0040);
        repeat (3) @(posedge clk);
        check("locked addr", 16'(target_addr), 16'h0037);
    endtask
    task automatic t_boot();
        pulses(9, 1'b1);
        pulses(3, 1'b0);
        pulses(9, 1'b1);
        check("boot uv early", 16'(fault_report[4]), 16'h0000);
        pulses(1, 1'b1);
        pulses(3, 1'b0);
        check("boot uv", 16'(fault_report[4]), 16'h0001);
    endtask
    task automatic t_hss();
        repeat (30) @(posedge clk);
        switch_node_high <= 1'b1;
        @(posedge clk);
        switch_node_high <= 1'b0;
        repeat (25) @(posedge clk);
        check("short", 16'({ls_on, hs_on, catastrophic_fault_out_n, current_report_en}),
              16'h0008);
    endtask
    task automatic t_min_off();
        pwm_request <= 1'b1;
        wait_hs(1'b1);
        pwm_request <= 1'b0;
        wait_hs(1'b0);
        pwm_request <= 1'b1;
        wait_hs(1'b1);
        check("off time", 16'(n >= 20 && n < 100), 16'h0001);
    endtask
    task automatic t_fov();
        i_host.write_reg(8'h60, 16'h1007);
        {boot_phase, vout_mv, ov_response} <= {1'b1, 12'hB54, 2'h1};
        repeat (5) @(posedge clk);
        check("ov blanked", 16'(fault_report[1]), 16'h0000);
        {boot_phase, dynamic_voltage_transition} <= 2'h1;
        repeat (5) @(posedge clk);
        check("fixed ov", 16'({ls_on, hs_on, fault_report[1]}), 16'h0005);
        vout_mv <= 12'h800;
        repeat (5) @(posedge clk);
        check("ov stop", 16'({ls_on, hs_on}), 16'h0000);
    endtask
    task automatic t_uv();
        {uv_response, uv_limit_mv, vout_mv} <= {2'h3, 12'h1F4, 12'h0FA};
        see_start(40);
        check("uv no start", 16'({s, hs_on, ls_on}), 16'h0000);
        vout_mv <= 12'h0F9;
        see_start(25);
        check("uv start", 16'(s), 16'h0001);
    endtask
    // Register threshold 100 mV above a 1000 mV target, PMBus threshold 0
    task automatic t_rov();
        i_host.write_reg(8'h5E, 16'h9000);
        {ov_response, vout_mv} <= {2'h1, 12'h41A};
        repeat (5) @(posedge clk);
        check("rov override", 16'(fault_report[1]), 16'h0000);
        vout_mv <= 12'h47E;
        repeat (5) @(posedge clk);
        check("rov drive", 16'({ls_on, hs_on, fault_report[1], regulator_ready_out}),
              16'h000A);
        check("rov ramp", 16'(ramped_target), 16'h0352);
        repeat (25) @(posedge clk);
        check("rov shutdown", 16'({ls_on, hs_on, ramped_target}), 16'h03E8);
    endtask
    task automatic t_ot();
        {ot_response, ot_fault_in, oc_fault_in, vcc_uvlo_in} <= 5'h1F;
        repeat (4) @(posedge clk);
        check("ot off", 16'({hs_on, ls_on}), 16'h0000);
        {ot_fault_in, ot_warn_in, oc_fault_in, vcc_uvlo_in} <= 4'h4;
        repeat (4) @(posedge clk);
        check("ot warm", 16'({hs_on, ls_on}), 16'h0000);
        ot_warn_in <= 1'b0;
        repeat (4) @(posedge clk);
        check("ot retry", 16'({hs_on, ls_on}), 16'h0001);
        check("fault bits", 16'(fault_report), 16'h0029);
        i_host.read_reg(8'h62, d);
        check("fault code", d, 16'h0029);
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        rst();
        t_regs();
        t_addr();
        rst();
        t_boot();
        rst();
        t_hss();
        rst();
        t_min_off();
        rst();
        t_fov();
        rst();
        t_uv();
        rst();
        t_rov();
        rst();
        t_ot();
        end_sim();
    end
endmodule
`default_nettype wire
